// file: src/spc_top.sv
`timescale 1ns/1ns
module spc_top #(
  parameter int SECTOR_BITS = spc_pkg::SECTOR_BITS,
  parameter int SECTOR_LSB  = spc_pkg::SECTOR_LSB
) (
  // System
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Serial link
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so_out,
  output logic      so_oe_n,
  // Flags shared with the rest of the flash
  output logic      write_in_progress,
  output logic      write_enable_latch,
  output logic      program_error
);
  import spc_pkg::*;

  localparam int SECTORS = 1 << SECTOR_BITS;

  // Link domain
  logic                   link_active;
  logic [5:0]             bit_cnt;
  logic [5:0]             cnt_now;
  logic [2:0]             bit_ph;
  logic [7:0]             cmd;
  logic [31:0]            addr;
  logic [7:0]             wr_data;
  logic [7:0]             out_byte;
  logic [2:0]             link_flags;
  logic [SECTOR_BITS-1:0] link_sector;
  logic [7:0]             read_byte;
  logic                   read_ok;

  // System domain
  logic                   cs_sync;
  logic                   cs_prev;
  logic                   frame_end;
  logic                   enable_hit;
  logic                   op_go;
  logic [15:0]            op_len;
  logic                   op_done;
  logic [7:0]             op_cmd;
  logic [SECTOR_BITS-1:0] op_sector;
  logic [7:0]             op_data;
  logic                   op_fail;
  spc_op_state_type       state;
  logic [SECTORS-1:0]     vol_bits;
  logic [SECTORS-1:0]     pers_bits;
  logic [7:0]             lock_reg;

  // Select high ends the frame; sck may stop, so this is the only frame reset
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      link_active <= 1'b0;
    end else begin
      link_active <= 1'b1;
    end
  end

  assign cnt_now     = link_active ? bit_cnt : 6'h00;
  assign link_sector = addr[SECTOR_LSB +: SECTOR_BITS];

  // Counter saturates so overlong frames never match an exact length
  always_ff @(posedge sck) begin
    bit_cnt <= (cnt_now == CNT_MAX) ? CNT_MAX : cnt_now + 6'h01;
    bit_ph  <= link_active ? bit_ph + 3'h1 : 3'h1;
  end

  always_ff @(posedge sck) begin
    if (cnt_now < CMD_END) begin
      cmd <= {cmd[6:0], si};
    end
  end

  always_ff @(posedge sck) begin
    if (cnt_now >= CMD_END && cnt_now < ADDR_END) begin
      addr <= {addr[30:0], si};
    end
  end

  always_ff @(posedge sck) begin
    if (cnt_now >= ADDR_END && cnt_now < DATA_END) begin
      wr_data <= {wr_data[6:0], si};
    end
  end

  // Flags only settle after a few edges of the frame, well before any output
  spc_sync #(
    .WIDTH (3)
  ) u_flag_sync (
    .clk (sck),
    .d   ({program_error, write_enable_latch, write_in_progress}),
    .q   (link_flags)
  );

  // Arrays are read quasi-static: they only change while busy, when reads are refused
  always_comb begin
    read_ok   = 1'b0;
    read_byte = BYTE_ZERO;
    case (cmd)
      CMD_STATUS1_READ: begin
        read_ok                 = bit_cnt >= CMD_END;
        read_byte[BUSY_POS]     = link_flags[0];
        read_byte[LATCH_POS]    = link_flags[1];
        read_byte[PERR_POS]     = link_flags[2];
      end
      CMD_VOL_READ: begin
        read_ok   = !link_flags[0] && bit_cnt >= ADDR_END;
        read_byte = vol_bits[link_sector] ? BYTE_ONES : BYTE_ZERO;
      end
      CMD_PERS_READ: begin
        read_ok   = !link_flags[0] && bit_cnt >= ADDR_END;
        read_byte = pers_bits[link_sector] ? BYTE_ONES : BYTE_ZERO;
      end
      CMD_LOCK_READ: begin
        read_ok   = !link_flags[0] && bit_cnt >= CMD_END;
        read_byte = lock_reg;
      end
      default: begin
        read_ok = 1'b0;
      end
    endcase
  end

  // Output changes on falling edges; byte reloads at each 8-bit boundary
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_out   <= 1'b0;
      so_oe_n  <= 1'b1;
      out_byte <= BYTE_ZERO;
    end else if (link_active && read_ok) begin
      so_oe_n <= 1'b0;
      if (bit_ph == 3'h0) begin
        so_out   <= read_byte[7];
        out_byte <= {read_byte[6:0], 1'b0};
      end else begin
        so_out   <= out_byte[7];
        out_byte <= {out_byte[6:0], 1'b0};
      end
    end
  end

  // Frame end seen in the system domain
  spc_sync #(
    .WIDTH (1)
  ) u_cs_sync (
    .clk (clk_sys),
    .d   (cs_n),
    .q   (cs_sync)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cs_prev <= 1'b1;
    end else begin
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync && !cs_prev;

  // Link registers are frozen here: sck is idle once select is high
  always_comb begin
    enable_hit = frame_end && state == OP_IDLE && cmd == CMD_WRITE_ENABLE
                 && bit_cnt == CMD_END;
    op_go    = 1'b0;
    op_len   = PROG_CYCLES;
    // Busy gate also drops erase suspend during the persistent erase
    if (frame_end && state == OP_IDLE && write_enable_latch) begin
      case (cmd)
        CMD_VOL_WRITE:    op_go = bit_cnt == DATA_END;
        CMD_PERS_PROGRAM: op_go = bit_cnt == ADDR_END;
        CMD_PERS_ERASE: begin
          op_go  = bit_cnt == CMD_END;
          op_len = ERASE_CYCLES;
        end
        CMD_LOCK_CLEAR:   op_go = bit_cnt == CMD_END;
        default:          op_go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      op_cmd    <= BYTE_ZERO;
      op_sector <= '0;
      op_data   <= BYTE_ZERO;
    end else if (op_go) begin
      op_cmd    <= cmd;
      op_sector <= link_sector;
      op_data   <= wr_data;
    end
  end

  spc_op_timer #(
    .WIDTH (16)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (op_go),
    .length  (op_len),
    .done    (op_done)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= OP_IDLE;
    end else begin
      unique case (state)
        OP_IDLE: if (op_go)   state <= OP_BUSY;
        OP_BUSY: if (op_done) state <= OP_IDLE;
        default:              state <= OP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_in_progress <= 1'b0;
    end else if (op_go) begin
      write_in_progress <= 1'b1;
    end else if (op_done) begin
      write_in_progress <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
    end else if (enable_hit) begin
      write_enable_latch <= 1'b1;
    end else if (op_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Locked persistent bits make program and erase fail
  assign op_fail = !lock_reg[0]
                   && (op_cmd == CMD_PERS_PROGRAM || op_cmd == CMD_PERS_ERASE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      program_error <= 1'b0;
    end else if (op_done && op_fail) begin
      program_error <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      vol_bits <= '1;
    end else if (op_done && op_cmd == CMD_VOL_WRITE) begin
      vol_bits[op_sector] <= op_data == BYTE_ONES;
    end
  end

  // Persistent bits have no power-up state here; they start erased
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pers_bits <= '1;
    end else if (op_done && !op_fail) begin
      if (op_cmd == CMD_PERS_PROGRAM) begin
        pers_bits[op_sector] <= 1'b0;
      end else if (op_cmd == CMD_PERS_ERASE) begin
        pers_bits <= '1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lock_reg <= LOCK_RESET;
    end else if (op_done && op_cmd == CMD_LOCK_CLEAR) begin
      lock_reg <= LOCK_CLEARED;
    end
  end

endmodule

// file: src/spc_pkg.sv
package spc_pkg;

  // Serial command codes
  localparam logic [7:0] CMD_STATUS1_READ   = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_VOL_READ       = 8'he0;
  localparam logic [7:0] CMD_VOL_WRITE      = 8'he1;
  localparam logic [7:0] CMD_PERS_READ      = 8'he2;
  localparam logic [7:0] CMD_PERS_PROGRAM   = 8'he3;
  localparam logic [7:0] CMD_PERS_ERASE     = 8'he4;
  localparam logic [7:0] CMD_LOCK_READ      = 8'ha7;
  localparam logic [7:0] CMD_LOCK_CLEAR     = 8'ha6;
  localparam logic [7:0] CMD_ERASE_SUSPEND  = 8'h75;

  // Frame bit counts, counted in rising serial clock edges
  localparam logic [5:0] CMD_END            = 6'h08;
  localparam logic [5:0] ADDR_END           = 6'h28;
  localparam logic [5:0] DATA_END           = 6'h30;
  localparam logic [5:0] CNT_MAX            = 6'h3f;

  // Sector geometry: 256 sectors of 256 kbyte
  localparam int         SECTOR_BITS        = 8;
  localparam int         SECTOR_LSB         = 18;

  // Status register 1 field positions
  localparam int         BUSY_POS           = 0;
  localparam int         LATCH_POS          = 1;
  localparam int         PERR_POS           = 6;

  // Register values
  localparam logic [7:0] BYTE_ONES          = 8'hff;
  localparam logic [7:0] BYTE_ZERO          = 8'h00;
  localparam logic [7:0] LOCK_RESET         = 8'h01;
  localparam logic [7:0] LOCK_CLEARED       = 8'h00;

  // Self-timed operation lengths
  localparam int         CLK_PERIOD_NS      = 10;
  localparam int         PROG_TIME_NS       = 2000;
  localparam int         ERASE_TIME_NS      = 20000;
  localparam logic [15:0] PROG_CYCLES  =
    16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ERASE_CYCLES =
    16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    OP_IDLE = 2'b01,
    OP_BUSY = 2'b10
  } spc_op_state_type;

endpackage

// file: src/spc_sync.sv
`timescale 1ns/1ns
module spc_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input  wire logic             clk,
  // Level to cross
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    stage1 <= d;
    q      <= stage1;
  end
endmodule

// file: src/spc_op_timer.sv
`timescale 1ns/1ns
module spc_op_timer #(
  parameter int WIDTH = 16
) (
  // System
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  output logic                  done
);
  logic [WIDTH-1:0] remain;
  logic             running;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      remain  <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain  <= length;
        running <= 1'b1;
      end else if (running) begin
        remain <= remain - 1'b1;
        if (remain <= 1) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end
endmodule

// file: tb/spc_assertions.sv
`timescale 1ns/1ns
module spc_assertions (
  // System
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe_n,
  // Flags
  input wire logic write_in_progress,
  input wire logic write_enable_latch,
  input wire logic program_error
);
  logic [15:0] busy_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence op_start;
    $rose(write_in_progress);
  endsequence
  sequence op_end;
    $fell(write_in_progress);
  endsequence
  // Busy length count, so a timer off by far is caught
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !write_in_progress) busy_cnt <= 16'h0000;
    else busy_cnt <= busy_cnt + 16'h0001;
  end
  start_needs_latch_a: assert property (op_start |-> write_enable_latch && cs_n)
    else $error("busy began without latch");
  end_clears_latch_a: assert property (op_end |-> !write_enable_latch)
    else $error("latch kept after op");
  op_length_a: assert property (op_end |->
    busy_cnt inside {[16'h00c3:16'h00cd], [16'h07cb:16'h07d5]})
    else $error("busy length wrong");
  latch_set_a: assert property ($rose(write_enable_latch) |-> cs_n && !write_in_progress)
    else $error("latch set mid frame");
  error_sticky_a: assert property (program_error |=> program_error)
    else $error("error flag dropped");
  oe_deselect_a: assert property (cs_n |-> so_oe_n && !so_out)
    else $error("output on while deselected");
  oe_on_fall_a: assert property ($fell(so_oe_n) |-> !cs_n && !sck)
    else $error("output began off falling edge");
  so_held_high_a: assert property (!cs_n && sck && $past(sck) && !$past(cs_n)
    |-> $stable(so_out))
    else $error("output moved while clock high");
endmodule
bind spc_top spc_assertions spc_assertions_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
  .so_out(so_out), .so_oe_n(so_oe_n), .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch), .program_error(program_error));

// file: tb/spc_host.sv
`timescale 1ns/1ns
module spc_host
  import spc_pkg::*;
(
  // Link
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  // 80 ns period, far below the read ceiling
  localparam int HALF = 40;
  initial begin
    sck = 1'b0;
    si = 1'b0;
    // Brief low so the select rise surely clears the link flops at start
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end
  // MSB first; the last 16 sampled bits come back
  task automatic frame(input logic [63:0] tx, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = tx[63-i];
      #HALF sck = 1'b1;
      // Undriven line shows the inverse, so a silent device is not read as data
      rd = {rd[14:0], so_oe_n ? ~so_out : so_out};
      #HALF sck = 1'b0;
    end
    #HALF cs_n = 1'b1;
    si = ~si;
    // Clock idle while the frame end is sampled
    #100;
  endtask
  // Idle before next command
  task automatic wait_idle(output logic [7:0] st);
    logic [15:0] rd;
    rd = 16'hffff;
    for (int k = 0; k < 40 && rd[0]; k++) begin
      frame({CMD_STATUS1_READ, 56'h0}, 24, rd);
    end
    st = rd[7:0];
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import spc_pkg::*;
  logic        clk_sys, reset_n, sck, cs_n, si, so_out, so_oe_n, busy_flag, latch_flag, perr;
  int          err_total;
  int          total_checks;
  logic [15:0] rd;
  logic [7:0]  st;
  spc_top spc_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .si(si), .so_out(so_out), .so_oe_n(so_oe_n), .write_in_progress(busy_flag),
    .write_enable_latch(latch_flag), .program_error(perr));
  spc_host spc_host_i (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic go(input logic [7:0] c, input int sec, input logic [7:0] d, input int n);
    @(posedge clk_sys);
    #1;
    spc_host_i.frame({c, 32'(sec) << SECTOR_LSB, d, 16'h0}, n, rd);
  endtask
  task automatic t_reset();
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0000);
    go(CMD_VOL_WRITE, 5, 8'h00, 48);
    spc_host_i.wait_idle(st);
    check({8'h00, st}, 16'h0000);
    go(CMD_VOL_READ, 5, 0, 56);
    check(rd, 16'hffff);
  endtask
  task automatic t_vol();
    go(CMD_WRITE_ENABLE, 0, 0, 8);
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0202);
    go(CMD_VOL_WRITE, 5, 8'h00, 47);
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0202);
    go(CMD_VOL_WRITE, 5, 8'h00, 48);
    spc_host_i.wait_idle(st);
    check({8'h00, st}, 16'h0000);
    go(CMD_VOL_READ, 5, 0, 56);
    check(rd, 16'h0000);
    go(CMD_VOL_READ, 6, 0, 56);
    check(rd, 16'hffff);
  endtask
  task automatic t_pers();
    go(CMD_WRITE_ENABLE, 0, 0, 8);
    go(CMD_PERS_PROGRAM, 3, 0, 40);
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0303);
    spc_host_i.wait_idle(st);
    go(CMD_PERS_READ, 3, 0, 56);
    check(rd, 16'h0000);
    go(CMD_PERS_READ, 4, 0, 56);
    check(rd, 16'hffff);
  endtask
  task automatic t_erase();
    go(CMD_WRITE_ENABLE, 0, 0, 8);
    go(CMD_PERS_ERASE, 0, 0, 16);
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0202);
    go(CMD_PERS_ERASE, 0, 0, 8);
    go(CMD_ERASE_SUSPEND, 0, 0, 8);
    go(CMD_STATUS1_READ, 0, 0, 24);
    check(rd, 16'h0303);
    spc_host_i.wait_idle(st);
    go(CMD_PERS_READ, 3, 0, 56);
    check(rd, 16'hffff);
  endtask
  task automatic t_lock();
    go(CMD_LOCK_READ, 0, 0, 24);
    check(rd, 16'h0101);
    go(CMD_WRITE_ENABLE, 0, 0, 8);
    go(CMD_LOCK_CLEAR, 0, 0, 8);
    spc_host_i.wait_idle(st);
    check({8'h00, st}, 16'h0000);
    go(CMD_LOCK_READ, 0, 0, 24);
    check(rd, 16'h0000);
    go(CMD_WRITE_ENABLE, 0, 0, 8);
    go(CMD_PERS_PROGRAM, 3, 0, 40);
    spc_host_i.wait_idle(st);
    check({st, 7'h00, perr}, 16'h4001);
  endtask
  initial begin
    err_total = 0;
    total_checks = 0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_vol();
    t_pers();
    t_erase();
    t_lock();
    tally_and_finish();
  end
  // About 40 frames and one long op fit well inside
  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end
endmodule
